// ---- eam_match.sv ----
`default_nettype none
module eam_match (
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               external_accept_in,
  input  wire logic               external_reject_in,
  input  wire eam_pkg::eam_frame_t frame_in,
  output eam_pkg::eam_result_t     result_out
);
  logic                   accept_sync;
  logic                   reject_sync;
  logic                   latched_reg;
  eam_pkg::eam_decision_t ext_dec;
  eam_pkg::eam_decision_t dec_reg;

  // Floating pins arrive high from the pad pull-ups
  eam_sync u_acc_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in (external_accept_in),
    .sync_out (accept_sync)
  );
  eam_sync u_rej_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in (external_reject_in),
    .sync_out (reject_sync)
  );

  // Decode of the two synchronised lines
  always_comb begin
    case ({accept_sync, reject_sync})
      2'h0: begin
        ext_dec = eam_pkg::EAM_DEC_NONE;
      end
      2'h2: begin
        ext_dec = eam_pkg::EAM_DEC_COPY;
      end
      2'h1, 2'h3: begin
        ext_dec = eam_pkg::EAM_DEC_NOCOPY;
      end
      default: begin
        ext_dec = eam_pkg::EAM_DEC_NOCOPY;
      end
    endcase
  end

  // Track the external decision within a frame
  // Reject overrides an earlier accept, so sync skew cannot copy
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dec_reg     <= eam_pkg::EAM_DEC_NONE;
      latched_reg <= 1'b0;
    end else if (frame_in.frame_start) begin
      dec_reg     <= eam_pkg::EAM_DEC_NONE;
      latched_reg <= 1'b0;
    end else if (!frame_in.status_due) begin
      case (dec_reg)
        eam_pkg::EAM_DEC_NONE: begin
          if (ext_dec != eam_pkg::EAM_DEC_NONE) begin
            dec_reg     <= ext_dec;
            latched_reg <= 1'b1;
          end
        end
        eam_pkg::EAM_DEC_COPY: begin
          if (ext_dec == eam_pkg::EAM_DEC_NOCOPY) begin
            dec_reg <= eam_pkg::EAM_DEC_NOCOPY;
          end
        end
        eam_pkg::EAM_DEC_NOCOPY: begin
          dec_reg <= eam_pkg::EAM_DEC_NOCOPY;
        end
        default: begin
          dec_reg     <= eam_pkg::EAM_DEC_NOCOPY;
          latched_reg <= 1'b1;
        end
      endcase
    end
  end

  // Result issued when the frame-status field is due
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      result_out <= eam_pkg::EAM_RESULT_RESET;
    end else if (frame_in.status_due) begin
      if (frame_in.copy_all_frames_mode) begin
        result_out.copy_frame <= 1'b1;
        result_out.addr_seen_and_copied_flags <=
          frame_in.internal_match;
      end else begin
        result_out.copy_frame <= frame_in.internal_match ||
          (dec_reg == eam_pkg::EAM_DEC_COPY);
        result_out.addr_seen_and_copied_flags <= frame_in.internal_match
          || (dec_reg == eam_pkg::EAM_DEC_COPY);
      end
      result_out.decision_valid <= 1'b1;
    end else begin
      result_out.decision_valid <= 1'b0;
    end
  end

  extern_copy_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      frame_in.status_due && !frame_in.copy_all_frames_mode &&
      dec_reg == eam_pkg::EAM_DEC_COPY
      |=> result_out.copy_frame &&
      result_out.addr_seen_and_copied_flags
    ) else $error("external accept did not copy");

  reject_block_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      frame_in.status_due && !frame_in.copy_all_frames_mode &&
      !frame_in.internal_match && dec_reg != eam_pkg::EAM_DEC_COPY
      |=> !result_out.copy_frame
    ) else $error("copy without any match");

  reject_flags_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      frame_in.status_due && !frame_in.copy_all_frames_mode &&
      !frame_in.internal_match && dec_reg == eam_pkg::EAM_DEC_NOCOPY
      |=> !result_out.addr_seen_and_copied_flags
    ) else $error("flags set on external reject");

  reject_wins_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !frame_in.frame_start && !frame_in.status_due && reject_sync
      |=> dec_reg == eam_pkg::EAM_DEC_NOCOPY
    ) else $error("reject did not override");

  accept_take_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !frame_in.frame_start && !frame_in.status_due &&
      accept_sync && !reject_sync && dec_reg == eam_pkg::EAM_DEC_NONE
      |=> dec_reg == eam_pkg::EAM_DEC_COPY && latched_reg
    ) else $error("accept not taken while armed");

  internal_flag_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      frame_in.status_due && frame_in.internal_match
      |=> result_out.addr_seen_and_copied_flags
    ) else $error("internal match lost flags");

  caf_ignore_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      frame_in.status_due && frame_in.copy_all_frames_mode
      |=> result_out.copy_frame &&
      result_out.addr_seen_and_copied_flags ==
      $past(frame_in.internal_match)
    ) else $error("copy-all mode not honoured");

  armed_hold_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !frame_in.frame_start && !latched_reg &&
      !accept_sync && !reject_sync
      |=> !latched_reg && dec_reg == eam_pkg::EAM_DEC_NONE
    ) else $error("decision taken while armed");

  frame_clear_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      frame_in.frame_start
      |=> !latched_reg && dec_reg == eam_pkg::EAM_DEC_NONE
    ) else $error("new frame kept old decision");

  sync_delay_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ##2 reject_sync == $past(external_reject_in, 2)
    ) else $error("reject sync depth wrong");

  accept_delay_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ##2 accept_sync == $past(external_accept_in, 2)
    ) else $error("accept sync depth wrong");

  valid_pulse_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      frame_in.status_due
      |=> result_out.decision_valid
    ) else $error("decision not issued");

  valid_single_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !frame_in.status_due
      |=> !result_out.decision_valid
    ) else $error("decision issued without status");

  result_hold_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !frame_in.status_due
      |=> $stable(result_out.copy_frame) &&
      $stable(result_out.addr_seen_and_copied_flags)
    ) else $error("result changed between frames");

  latch_keep_a:
    assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      latched_reg && !frame_in.frame_start
      |=> latched_reg && ($stable(dec_reg) ||
      dec_reg == eam_pkg::EAM_DEC_NOCOPY)
    ) else $error("latched decision changed");
endmodule
`default_nettype wire

// ---- eam_pkg.sv ----
`default_nettype none
package eam_pkg;
  // Copy decision codes
  typedef enum logic [1:0] {
    EAM_DEC_NONE,
    EAM_DEC_COPY,
    EAM_DEC_NOCOPY
  } eam_decision_t;

  // Frame-side inputs from the receive path
  typedef struct packed {
    logic frame_start;
    logic status_due;
    logic internal_match;
    logic copy_all_frames_mode;
  } eam_frame_t;

  // Decision outputs toward the receive path
  typedef struct packed {
    logic copy_frame;
    logic addr_seen_and_copied_flags;
    logic decision_valid;
  } eam_result_t;

  localparam int          EAM_SYNC_STAGES = 2;
  localparam logic [1:0]  EAM_SYNC_RESET  = 2'h3;
  localparam eam_result_t EAM_RESULT_RESET = '0;
endpackage
`default_nettype wire

// ---- eam_sync.sv ----
`default_nettype none
module eam_sync (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_reg;

  // Two-stage synchroniser, resets high like a pulled-up pin
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_reg <= eam_pkg::EAM_SYNC_RESET[0];
      sync_out <= eam_pkg::EAM_SYNC_RESET[1];
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- eam_ext_model.sv ----
`default_nettype none
module eam_ext_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       fit_in,
  input  wire logic [1:0] level_in,
  output wire logic       accept_out,
  output wire logic       reject_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic on_reg;
  always_ff @(posedge clk_in) begin
    on_reg <= rst_n_in && fit_in;
  end
  // Floats in reset and when unused
  assign accept_out = (on_reg && rst_n_in) ? level_in[1] : 1'bz;
  assign reject_out = (on_reg && rst_n_in) ? level_in[0] : 1'bz;
endmodule
`default_nettype wire

// ---- tb_eam_match.sv ----
`default_nettype none
module tb_eam_match;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clk_in = 1'b0;
  logic                 rst_n_in = 1'b0;
  logic                 fit = 1'b1;
  logic [1:0]           lvl = 2'h0;
  eam_pkg::eam_frame_t  frame_in = '0;
  eam_pkg::eam_result_t result_out;
  tri1                  acc_w;
  tri1                  rej_w;
  int                   miscompares = 0;
  int                   compares = 0;
  always #25 clk_in = ~clk_in;
  eam_ext_model ext_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .fit_in(fit),
    .level_in(lvl), .accept_out(acc_w), .reject_out(rej_w));
  eam_match dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .external_accept_in(acc_w), .external_reject_in(rej_w),
    .frame_in(frame_in), .result_out(result_out));
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic en, input logic [1:0] lv,
                       input logic [1:0] late, input logic caf,
                       input logic im, input logic ec, input logic ef);
    @(negedge clk_in);
    frame_in = '{1'b1, 1'b0, im, caf};
    fit = en;
    lvl = lv;
    @(negedge clk_in);
    frame_in.frame_start = 1'b0;
    @(negedge clk_in);
    lvl = late;
    repeat (3) @(negedge clk_in);
    frame_in.status_due = 1'b1;
    @(negedge clk_in);
    frame_in.status_due = 1'b0;
    check({1'b0, result_out.decision_valid,
           result_out.addr_seen_and_copied_flags}, {2'h1, ef});
    check({2'h0, result_out.copy_frame}, {2'h0, ec});
    fit = 1'b1;
    lvl = 2'h0;
    @(negedge clk_in);
    check({1'b0, result_out.decision_valid,
           result_out.copy_frame}, {2'h0, ec});
    repeat (2) @(negedge clk_in);
  endtask
  task automatic test_external;
    frame(1'b1, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    frame(1'b1, 2'h2, 2'h2, 1'b0, 1'b0, 1'b1, 1'b1);
    frame(1'b1, 2'h1, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    frame(1'b1, 2'h3, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0);
    frame(1'b1, 2'h2, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0);
    frame(1'b1, 2'h0, 2'h2, 1'b0, 1'b0, 1'b1, 1'b1);
  endtask
  task automatic test_reset;
    @(negedge clk_in);
    rst_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check(result_out, eam_pkg::EAM_RESULT_RESET);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    frame(1'b1, 2'h2, 2'h2, 1'b0, 1'b0, 1'b1, 1'b1);
  endtask
  task automatic test_internal_and_all;
    frame(1'b1, 2'h1, 2'h1, 1'b0, 1'b1, 1'b1, 1'b1);
    frame(1'b1, 2'h1, 2'h1, 1'b1, 1'b0, 1'b1, 1'b0);
    frame(1'b1, 2'h2, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0);
    frame(1'b1, 2'h0, 2'h0, 1'b1, 1'b1, 1'b1, 1'b1);
    frame(1'b0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic complete_run;
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk_in);
    check(result_out, eam_pkg::EAM_RESULT_RESET);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    test_external();
    test_reset();
    test_internal_and_all();
    complete_run();
  end
endmodule
`default_nettype wire
